/* dv/fbp_flash_ctrl_bench.sv */
// Self-checking bench for the flash erase and protection controller
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_ctrl_bench;
	import fbp_pkg::*;
	logic clk_i = 0, rst_n_i = 0, cmd_valid_i = 0, cmd_erase_i = 0, go = 0;
	logic fr, dr, br, fv, dv, bv, fe, de, be, cmd_ready_o, cmd_done_o, cmd_err_o;
	logic [1:0] sel = 0;
	logic [15:0] cmd_addr_i = 0, rd_addr = 0, ma;
	logic [31:0] cmd_wdata_i = 0, fd, dd, bd;
	logic [127:0] prot_ro_i = 0, prot_xo_i = 0;
	int bad_count = 0, n_compared = 0;
	fbp_req_model u_req (.go_i(go), .sel_i(sel), .addr_i(rd_addr), .fetch_req_o(fr),
		.data_req_o(dr), .dbg_req_o(br), .addr_o(ma));
	fbp_flash_ctrl DUT (.clk_i, .rst_n_i, .prot_ro_i, .prot_xo_i, .fetch_req_i(fr),
		.fetch_addr_i(ma), .fetch_rdata_o(fd), .fetch_valid_o(fv), .fetch_err_o(fe),
		.data_req_i(dr), .data_addr_i(ma), .data_rdata_o(dd), .data_valid_o(dv),
		.data_err_o(de), .dbg_req_i(br), .dbg_addr_i(ma), .dbg_rdata_o(bd),
		.dbg_valid_o(bv), .dbg_err_o(be), .cmd_valid_i, .cmd_erase_i, .cmd_addr_i,
		.cmd_wdata_i, .cmd_ready_o, .cmd_done_o, .cmd_err_o);
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic er, input logic [15:0] ad, input logic [31:0] wd, input logic ex);
		int n;
		n = 0;
		cmd_valid_i <= 1'b1;
		cmd_erase_i <= er;
		cmd_addr_i <= ad;
		cmd_wdata_i <= wd;
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		do begin
			@(negedge clk_i);
			n++;
		end while (cmd_done_o !== 1'b1 && n < 300);
		chk(n, er && !ex ? 257 : 1);
		chk(cmd_err_o, ex);
		chk(cmd_ready_o, 1'b1);
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [1:0] s, input logic [15:0] ad, input logic [31:0] ed,
		input logic ee);
		go <= 1'b1;
		sel <= s;
		rd_addr <= ad;
		@(posedge clk_i);
		go <= 1'b0;
		@(negedge clk_i);
		chk(s == 0 ? fv : s == 1 ? dv : bv, 1'b1);
		chk(s == 0 ? fd : s == 1 ? dd : bd, ed);
		chk(s == 0 ? fe : s == 1 ? de : be, ee);
		@(posedge clk_i);
	endtask
	task automatic t_erase_prog;
		cmd(1, 16'h0000, 0, 0);
		cmd(1, 16'h0100, 0, 0);
		rd(0, 16'h0005, ERASED_WORD, 0);
		cmd(0, 16'h0005, 32'h1234_5678, 0);
		cmd(0, 16'h0005, 32'hFF00_FFFF, 0);
		cmd(1, 16'h0100, 0, 0);
		rd(2, 16'h0005, 32'h1200_5678, 0);
		rd(1, 16'h0123, ERASED_WORD, 0);
		$display("test erase_prog done");
	endtask
	task automatic t_read_only;
		prot_ro_i[0] <= 1'b1;
		cmd(1, 16'h0000, 0, 1);
		cmd(0, 16'h0005, 32'h0000_0000, 1);
		rd(1, 16'h0005, 32'h1200_5678, 0);
		prot_ro_i[0] <= 1'b0;
		$display("test read_only done");
	endtask
	task automatic t_exec_only;
		cmd(1, 16'h0200, 0, 0);
		cmd(0, 16'h0258, 32'hA5A5_0F0F, 0);
		prot_xo_i[1] <= 1'b1;
		cmd(0, 16'h0258, 32'h0000_0000, 1);
		cmd(1, 16'h0300, 0, 1);
		rd(0, 16'h0258, 32'hA5A5_0F0F, 0);
		rd(1, 16'h0258, 32'h0000_0000, 1);
		rd(2, 16'h03FF, 32'h0000_0000, 1);
		rd(1, 16'h01FF, ERASED_WORD, 0);
		$display("test exec_only done");
	endtask
	task automatic t_reset;
		cmd_valid_i <= 1'b1;
		cmd_erase_i <= 1'b1;
		cmd_addr_i <= 16'h0400;
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b0;
		@(negedge clk_i);
		chk(cmd_ready_o, 1'b0);
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		chk(cmd_ready_o, RST_READY);
		chk(cmd_done_o, 1'b0);
		@(posedge clk_i);
		cmd(0, 16'h0401, 32'h0F0F_0000, 0);
		rd(1, 16'h0401, 32'h0F0F_0000, 0);
		$display("test reset done");
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_erase_prog();
		t_read_only();
		t_exec_only();
		t_reset();
		summarize();
	end
	initial begin
		#(4000 * 100);
		bad_count++;
		summarize();
	end
endmodule // fbp_flash_ctrl_bench
`default_nettype wire

/* dv/fbp_flash_ctrl_sva.sv */
// Port-level timing and protection checker for the flash controller
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_ctrl_sva #(
	parameter int unsigned FLASH_SIZE = 262144,
	parameter int unsigned AW = $clog2(FLASH_SIZE/4),
	parameter int unsigned U = FLASH_SIZE/2048
) (
	input wire logic clk_i, rst_n_i, fetch_req_i, data_req_i, dbg_req_i,
	input wire logic cmd_valid_i, cmd_erase_i,
	input wire logic [U-1:0] prot_ro_i, prot_xo_i,
	input wire logic [AW-1:0] data_addr_i, dbg_addr_i, cmd_addr_i,
	input wire logic [31:0] data_rdata_o,
	input wire logic fetch_valid_o, fetch_err_o, data_valid_o, data_err_o,
	input wire logic dbg_valid_o, dbg_err_o, cmd_ready_o, cmd_done_o, cmd_err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic take, prot;
	assign take = cmd_valid_i && cmd_ready_o;
	// Unit index is the word address above the 512-word unit
	assign prot = prot_ro_i[cmd_addr_i[AW-1:9]] || prot_xo_i[cmd_addr_i[AW-1:9]];
	a_fetch_latency: assert property (fetch_req_i |=> fetch_valid_o)
		else $error("fetch answer late");
	a_data_latency: assert property (data_req_i |=> data_valid_o)
		else $error("data answer late");
	a_dbg_latency: assert property (dbg_req_i |=> dbg_valid_o)
		else $error("debug answer late");
	a_fetch_no_err: assert property (fetch_valid_o |-> !fetch_err_o)
		else $error("fetch refused");
	a_xo_data_deny: assert property (data_req_i && prot_xo_i[data_addr_i[AW-1:9]]
		|=> data_err_o && data_rdata_o == 32'h0000_0000) else $error("data load not denied");
	a_xo_dbg_deny: assert property (dbg_req_i && prot_xo_i[dbg_addr_i[AW-1:9]]
		|=> dbg_err_o) else $error("debug read not denied");
	a_prot_refuse: assert property (take && prot |=> cmd_done_o && cmd_err_o)
		else $error("protected command not refused");
	a_erase_length: assert property (take && cmd_erase_i && !prot
		|=> !cmd_ready_o ##256 cmd_done_o && !cmd_err_o) else $error("erase length wrong");
	a_prog_done: assert property (take && !cmd_erase_i && !prot
		|=> cmd_done_o && !cmd_err_o) else $error("program not done");
endmodule // fbp_flash_ctrl_sva
bind fbp_flash_ctrl fbp_flash_ctrl_sva #(.FLASH_SIZE(FLASH_SIZE)) u_sva (.clk_i, .rst_n_i,
	.fetch_req_i, .data_req_i, .dbg_req_i, .cmd_valid_i, .cmd_erase_i, .prot_ro_i, .prot_xo_i,
	.data_addr_i, .dbg_addr_i, .cmd_addr_i, .data_rdata_o, .fetch_valid_o, .fetch_err_o,
	.data_valid_o, .data_err_o, .dbg_valid_o, .dbg_err_o, .cmd_ready_o, .cmd_done_o, .cmd_err_o);
`default_nettype wire

/* dv/fbp_req_model.sv */
// Requester standing in for instruction fetch, data loads and debugger
`timescale 1ns/1ps
`default_nettype none
module fbp_req_model (
	input wire logic go_i,
	input wire logic [1:0] sel_i,
	input wire logic [15:0] addr_i,
	output logic fetch_req_o,
	output logic data_req_o,
	output logic dbg_req_o,
	output logic [15:0] addr_o
);
	assign fetch_req_o = go_i && sel_i == 2'h0;
	assign data_req_o = go_i && sel_i == 2'h1;
	assign dbg_req_o = go_i && sel_i == 2'h2;
	// Idle address is scrambled so a stale value can never pass for a request
	assign addr_o = go_i ? addr_i : ~addr_i;
endmodule // fbp_req_model
`default_nettype wire

/* rtl/fbp_chk_if.sv */
// Protection lookup request and verdict between controller and checkers
`timescale 1ns/1ps
`default_nettype none
interface fbp_chk_if #(
	parameter int unsigned AW = 16
);
	logic [AW-1:0] addr;
	fbp_pkg::fbp_acc_t kind;
	logic deny;
	modport req (output addr, output kind, input deny);
	modport judge (input addr, input kind, output deny);
endinterface
`default_nettype wire

/* rtl/fbp_flash_ctrl.sv */
// Flash array controller with block erase, word program and 2-KB protection
// Function
// - Flash reads answer the processor one clock after the request.
// - 256 KB array in 1-KB blocks, each erasable alone.
// - A finished block erase leaves all bits of that block at one.
// - Protection works on 2-KB units of two adjacent blocks, each set independently.
// - Read-only units refuse every erase and program.
// - Execute-only units also refuse every erase and program.
// - Execute-only contents go only to instruction fetches.
// - Execute-only units deny data loads and debugger reads.
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_ctrl
	import fbp_pkg::*;
#(
	parameter int unsigned FLASH_SIZE = fbp_pkg::FLASH_BYTES,
	parameter int unsigned DW = fbp_pkg::DATA_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Protection settings, one bit per 2-KB unit
	input wire logic [FLASH_SIZE/fbp_pkg::UNIT_BYTES-1:0] prot_ro_i,
	input wire logic [FLASH_SIZE/fbp_pkg::UNIT_BYTES-1:0] prot_xo_i,
	// Instruction fetch port
	input wire logic fetch_req_i,
	input wire logic [$clog2(FLASH_SIZE/fbp_pkg::WORD_BYTES)-1:0] fetch_addr_i,
	output logic [DW-1:0] fetch_rdata_o,
	output logic fetch_valid_o,
	output logic fetch_err_o,
	// Processor data read port
	input wire logic data_req_i,
	input wire logic [$clog2(FLASH_SIZE/fbp_pkg::WORD_BYTES)-1:0] data_addr_i,
	output logic [DW-1:0] data_rdata_o,
	output logic data_valid_o,
	output logic data_err_o,
	// Debugger read port
	input wire logic dbg_req_i,
	input wire logic [$clog2(FLASH_SIZE/fbp_pkg::WORD_BYTES)-1:0] dbg_addr_i,
	output logic [DW-1:0] dbg_rdata_o,
	output logic dbg_valid_o,
	output logic dbg_err_o,
	// Program and erase command port
	input wire logic cmd_valid_i,
	input wire logic cmd_erase_i,
	input wire logic [$clog2(FLASH_SIZE/fbp_pkg::WORD_BYTES)-1:0] cmd_addr_i,
	input wire logic [DW-1:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic cmd_done_o,
	output logic cmd_err_o
);
	import fbp_pkg::*;

	localparam int unsigned WORDS = FLASH_SIZE / WORD_BYTES;
	localparam int unsigned AW = $clog2(WORDS);
	localparam int unsigned BLK_WORDS = BLOCK_BYTES / WORD_BYTES;
	localparam int unsigned BW = $clog2(BLK_WORDS);
	localparam int unsigned UNITS = FLASH_SIZE / UNIT_BYTES;
	localparam logic [BW-1:0] BLK_LAST = BW'(BLK_WORDS - 1);

	// Everything that changes on a clock edge, apart from the array itself
	typedef struct packed {
		fbp_state_t state;
		logic [AW-1:0] ptr;
		logic ready;
		logic done;
		logic err;
		logic [NUM_RD_PORTS-1:0] rvalid;
		logic [NUM_RD_PORTS-1:0] rerr;
		logic [NUM_RD_PORTS-1:0][DW-1:0] rdata;
	} fbp_ctl_t;

	localparam fbp_ctl_t CTL_RST = '{
		state: ST_IDLE,
		ptr: '0,
		ready: RST_READY,
		done: 1'b0,
		err: 1'b0,
		rvalid: '0,
		rerr: '0,
		rdata: '0
	};

	fbp_ctl_t ctl_q;
	fbp_ctl_t ctl_d;
	// Nonvolatile contents: deliberately not touched by reset
	logic [DW-1:0] mem_q [WORDS];
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [DW-1:0] mem_wdata;
	logic [NUM_CHK-1:0] deny;
	logic [NUM_RD_PORTS-1:0] rd_req;
	logic [NUM_RD_PORTS-1:0][AW-1:0] rd_addr;

	// Command decode shared by the state machine
	logic cmd_take;
	logic [AW-1:0] erase_base;
	logic [DW-1:0] prog_word;

	fbp_chk_if #(.AW(AW)) chk [NUM_CHK] ();

	// Every requester gets its own verdict each cycle, so reads never queue
	assign chk[PORT_FETCH].addr = fetch_addr_i;
	assign chk[PORT_FETCH].kind = ACC_FETCH;
	assign chk[PORT_DATA].addr = data_addr_i;
	assign chk[PORT_DATA].kind = ACC_DATA;
	assign chk[PORT_DEBUG].addr = dbg_addr_i;
	assign chk[PORT_DEBUG].kind = ACC_DEBUG;
	assign chk[PORT_MODIFY].addr = cmd_addr_i;
	assign chk[PORT_MODIFY].kind = ACC_MODIFY;
	assign deny[PORT_FETCH] = chk[PORT_FETCH].deny;
	assign deny[PORT_DATA] = chk[PORT_DATA].deny;
	assign deny[PORT_DEBUG] = chk[PORT_DEBUG].deny;
	assign deny[PORT_MODIFY] = chk[PORT_MODIFY].deny;

	for (genvar g = 0; g < NUM_CHK; g++) begin : g_chk
		fbp_prot_check #(
			.AW(AW),
			.UNITS(UNITS)
		) u_chk (
			.bus(chk[g]),
			.prot_ro_i(prot_ro_i),
			.prot_xo_i(prot_xo_i)
		);
	end

	assign rd_req = {dbg_req_i, data_req_i, fetch_req_i};
	assign rd_addr = {dbg_addr_i, data_addr_i, fetch_addr_i};

	// Offers made while an erase runs are held off, not lost
	assign cmd_take = cmd_valid_i & ctl_q.ready;
	// Erase always starts at the first word of the addressed 1-KB block
	assign erase_base = {cmd_addr_i[AW-1:BW], BW'(0)};
	// Programming can only clear bits, as in a real flash cell
	assign prog_word = mem_q[cmd_addr_i] & cmd_wdata_i;

	always_comb begin
		ctl_d = ctl_q;
		ctl_d.done = 1'b0;
		ctl_d.err = 1'b0;
		mem_we = 1'b0;
		mem_waddr = '0;
		mem_wdata = '0;

		// All three readers served in parallel, answer registered next cycle
		for (int i = 0; i < NUM_RD_PORTS; i++) begin
			ctl_d.rvalid[i] = rd_req[i];
			ctl_d.rerr[i] = rd_req[i] & deny[i];
			// Denied reads return zeros so nothing of a hidden unit leaks
			ctl_d.rdata[i] = (rd_req[i] && !deny[i]) ? mem_q[rd_addr[i]] : '0;
		end

		case (ctl_q.state)
			ST_IDLE: begin
				if (cmd_take) begin
					if (deny[PORT_MODIFY]) begin
						// Array left alone, requester told
						ctl_d.err = 1'b1;
						ctl_d.done = 1'b1;
					end else if (cmd_erase_i) begin
						// Erase walks only the addressed 1-KB block
						ctl_d.state = ST_ERASE;
						ctl_d.ptr = erase_base;
						ctl_d.ready = 1'b0;
					end else begin
						mem_we = 1'b1;
						mem_waddr = cmd_addr_i;
						mem_wdata = prog_word;
						ctl_d.done = 1'b1;
					end
				end
			end
			ST_ERASE: begin
				// Readers of this block see old words until the walk reaches them
				mem_we = 1'b1;
				mem_waddr = ctl_q.ptr;
				mem_wdata = ERASED_WORD[DW-1:0];
				if (ctl_q.ptr[BW-1:0] == BLK_LAST) begin
					ctl_d.state = ST_IDLE;
					ctl_d.ready = 1'b1;
					ctl_d.done = 1'b1;
				end else begin
					ctl_d.ptr = ctl_q.ptr + AW'(1);
				end
			end
			default: begin
				ctl_d = CTL_RST;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			// Control state only: an erase cut short by reset leaves a part-erased block
			ctl_q <= CTL_RST;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem_q[mem_waddr] <= mem_wdata;
		end
	end

	// Read answers, registered one cycle after each request
	assign fetch_rdata_o = ctl_q.rdata[PORT_FETCH];
	assign fetch_valid_o = ctl_q.rvalid[PORT_FETCH];
	assign fetch_err_o = ctl_q.rerr[PORT_FETCH];
	assign data_rdata_o = ctl_q.rdata[PORT_DATA];
	assign data_valid_o = ctl_q.rvalid[PORT_DATA];
	assign data_err_o = ctl_q.rerr[PORT_DATA];
	assign dbg_rdata_o = ctl_q.rdata[PORT_DEBUG];
	assign dbg_valid_o = ctl_q.rvalid[PORT_DEBUG];
	assign dbg_err_o = ctl_q.rerr[PORT_DEBUG];

	// Command status
	assign cmd_ready_o = ctl_q.ready;
	assign cmd_done_o = ctl_q.done;
	assign cmd_err_o = ctl_q.err;
endmodule // fbp_flash_ctrl
`default_nettype wire

/* rtl/fbp_pkg.sv */
// Shared constants and types for the flash block erase and protection controller
package fbp_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned WORD_BYTES = 4;
	localparam int unsigned FLASH_BYTES = 262144;
	localparam int unsigned BLOCK_BYTES = 1024;
	localparam int unsigned UNIT_BYTES = 2048;
	localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
	localparam int unsigned NUM_RD_PORTS = 3;
	localparam int unsigned NUM_CHK = 4;
	localparam int unsigned PORT_FETCH = 0;
	localparam int unsigned PORT_DATA = 1;
	localparam int unsigned PORT_DEBUG = 2;
	localparam int unsigned PORT_MODIFY = 3;
	localparam logic RST_READY = 1'b1;

	typedef enum logic [1:0] {
		ACC_FETCH = 2'h0,
		ACC_DATA = 2'h1,
		ACC_DEBUG = 2'h2,
		ACC_MODIFY = 2'h3
	} fbp_acc_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_ERASE = 1'b1
	} fbp_state_t;
endpackage

/* rtl/fbp_prot_check.sv */
// Per-access protection verdict for one requester
`timescale 1ns/1ps
`default_nettype none
module fbp_prot_check #(
	parameter int unsigned AW = 16,
	parameter int unsigned UNITS = 128
) (
	// Request and verdict
	fbp_chk_if.judge bus,
	// Protection settings, one bit per 2-KB unit
	input wire logic [UNITS-1:0] prot_ro_i,
	input wire logic [UNITS-1:0] prot_xo_i
);
	import fbp_pkg::*;
	localparam int unsigned UW = $clog2(UNITS);

	logic [UW-1:0] unit;
	logic ro;
	logic xo;

	// Two 1-KB erase blocks share one unit
	assign unit = bus.addr[AW-1 -: UW];
	assign ro = prot_ro_i[unit];
	assign xo = prot_xo_i[unit];

	always_comb begin
		bus.deny = 1'b0;
		if (bus.kind == ACC_MODIFY) begin
			bus.deny = ro | xo;
		end else if (bus.kind != ACC_FETCH) begin
			// Read-only units stay readable by all; execute-only only by fetch
			bus.deny = xo;
		end
	end
endmodule // fbp_prot_check
`default_nettype wire
